//--- pkg/hmic_map.svh
// Purpose: Offsets, field positions, reset values and timing figures of the monitor interrupt block
// Assumes: Included by bare name from the top-level design file only
// Notes:   Times are kept in their own unit; the pulse cycle count is derived in the modules, the step count is given here in cycles
`ifndef HMIC_MAP_SVH
`define HMIC_MAP_SVH

`define HMIC_CLK_MHZ          50
`define HMIC_PULSE_MS         20
`define HMIC_NAND_PROP_NS     200
`define HMIC_TEMP_COMPARATOR  8'h7f
`define HMIC_RAM_DEPTH        32
`define HMIC_RAM_LAST         5'h1f
`define HMIC_ST1_TEMP         0
`define HMIC_ST2_BOARD_ALERT  0
`define HMIC_ST2_CHASSIS      1
`define HMIC_ST2_CHAINED      2
`define HMIC_ST2_RAM_OVF      3
`define HMIC_STATUS_RESET     8'h00
`define HMIC_STEP_CYCLES      1024

`endif

//--- pkg/hmic_pkg.sv
// Purpose: Types shared by the monitor interrupt block
// Assumes: Takes no constants from hmic_map.svh
// Notes:   Loop state codes are written out
`default_nettype none
package hmic_pkg;
    typedef enum logic [1:0] {
        HMIC_LOOP_IDLE = 2'b00,
        HMIC_LOOP_RUN  = 2'b01,
        HMIC_LOOP_HOLD = 2'b10
    } hmic_loop_t;
    typedef logic signed [7:0] hmic_temp_t;
endpackage
`default_nettype wire

//--- src/hmic_sync.sv
// Purpose: Three-stage input conditioner with a registered output for pin-level signals
// Assumes: Inputs are asynchronous to mclk
// Notes:   A change is taken only once the second and third stages agree
`default_nettype none
module hmic_sync
    import hmic_pkg::*;
#(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         mclk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q, out_d;

    // Output follows only where two settled stages agree
    always_comb begin
        out_d = (s2_q & s3_q) | (out_q & (s2_q | s3_q));
    end

    // First stage feeds the second and nothing else
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q  <= INIT;
            s2_q  <= INIT;
            s3_q  <= INIT;
            out_q <= INIT;
        end else begin
            s1_q  <= din;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign dout = out_q;

    initial begin
        if (W < 1) $error("hmic_sync: width must be at least 1");
    end
endmodule
`default_nettype wire

//--- src/hmic_top.sv
// Purpose: Interrupt and control logic of a hardware monitor
// Assumes: Readings and limits are presented on the mclk domain; pins arrive asynchronously
// Notes:   Status clears on read; chassis, sysmgmt and reset outputs are open drain as o/oe pairs driving low
//
// Contract
// RQ1 - Temperature and setpoints are 8-bit two's complement, one degree per LSB.
// RQ2 - Default mode: reading above overtemp sets temperature bit, held until status 1 read.
// RQ3 - After raised and cleared, next temperature event needs reading below hysteresis.
// RQ4 - Hysteresis at 127 gives thermostat mode: set whenever reading exceeds overtemp.
// RQ5 - Thermostat: read clears bit, next measurement sets it again while still hot.
// RQ6 - Thermostat: bit stops reasserting within two loops after falling below overtemp.
// RQ7 - Every channel limit compare and RAM overflow beyond 32 bytes raise interrupts.
// RQ8 - Low board_temp_alert_in is an external interrupt source, wire-ORed sensors.
// RQ9 - High chassis input interrupts; self-clearing bit drives line low 20 ms.
// RQ10 - Low chained_sysmgmt_in is a source and passes through to sysmgmt_irq_out.
// RQ11 - Two status registers record sources; each output has its own per-source masks.
// RQ12 - Configuration bits enable each output and choose host_irq_out signalling mode.
// RQ13 - Status read returns contents then clears; later reads see cleared value.
// RQ14 - Clearing by read releases the interrupt line until the loop updates status.
// RQ15 - Host waits at least 1.5 seconds between status reads.
// RQ16 - irq_line_hold clears interrupt outputs and halts the loop until it drops.
// RQ17 - Power-switch bypass output goes low while configuration bit 6 is high.
// RQ18 - With sysmgmt mask 2 bit 7 set, bit 4 pulses reset low 20 ms, self-clears.
// RQ19 - Self-test codes written at the code ports fill RAM, advancing the write pointer.
// RQ20 - RAM holds 32 bytes; a further write interrupts and the pointer stops.
// RQ21 - RAM reads at 00h-1Fh use their own auto-increment pointer.
// RQ22 - Start low, hold high, tester pulling sysmgmt low enters connectivity test mode.
// RQ23 - In test mode a single pin toggle shows on connectivity_test_out within 200 ns.
// RQ24 - Round-robin loop compares each channel once per loop, updating status per step.
`default_nettype none
`include "hmic_map.svh"
module hmic_top
    import hmic_pkg::*;
#(
    parameter int NCH         = 8,
    parameter int STEP_CYCLES = `HMIC_STEP_CYCLES,
    parameter int PULSE_CYC   = `HMIC_PULSE_MS * 1000 * `HMIC_CLK_MHZ,
    parameter int NAND_W      = 8
) (
    input  wire logic              mclk,
    input  wire logic              arst_n,
    input  wire logic              cfg_start,
    input  wire logic              cfg_irq_line_hold,
    input  wire logic              cfg_host_irq_en,
    input  wire logic              cfg_sysmgmt_irq_en,
    input  wire logic              cfg_host_irq_pulse,
    input  wire logic              cfg_pwr_bypass,
    input  wire logic              cfg_reset_pulse_wr,
    input  wire logic              chassis_clr_wr,
    input  wire logic [7:0]        host_mask1,
    input  wire logic [7:0]        host_mask2,
    input  wire logic [7:0]        sysmgmt_mask1,
    input  wire logic [7:0]        sysmgmt_mask2,
    output logic [$clog2(NCH)-1:0] chan_sel,
    input  wire logic [7:0]        chan_value,
    input  wire logic [7:0]        chan_hi_limit,
    input  wire logic [7:0]        chan_lo_limit,
    input  wire hmic_temp_t        overtemp_setpoint,
    input  wire hmic_temp_t        hysteresis_setpoint,
    input  wire logic              stat1_rd,
    input  wire logic              stat2_rd,
    output logic [7:0]             stat_rdata,
    output logic                   loop_done,
    input  wire logic              board_temp_alert_in,
    input  wire logic              chained_sysmgmt_in,
    input  wire logic              chassis_i,
    output logic                   chassis_o,
    output logic                   chassis_oe,
    output logic                   chassis_clr_busy,
    output logic                   host_irq_out,
    input  wire logic              sysmgmt_irq_i,
    output logic                   sysmgmt_irq_o,
    output logic                   sysmgmt_irq_oe,
    output logic                   reset_o,
    output logic                   reset_oe,
    output logic                   cfg_reset_busy,
    output logic                   pwr_bypass_n,
    input  wire logic              post_wr,
    input  wire logic [7:0]        post_wdata,
    input  wire logic              post_rd_load,
    input  wire logic [4:0]        post_rd_addr,
    input  wire logic              post_rd,
    output logic [7:0]             post_rdata,
    input  wire logic [NAND_W-1:0] nand_pins,
    output logic                   conn_test_mode,
    output logic                   connectivity_test_out
);
    localparam int CW = $clog2(NCH);

    // Pin conditioning: alerts, chassis line, tester pull on sysmgmt, test pins
    logic alert_n_s, chained_n_s, chassis_s, smi_pin_s;
    logic [NAND_W-1:0] nand_s;
    hmic_sync #(.W(4), .INIT(4'hf)) u_sync_pins (
        .mclk   (mclk),
        .arst_n (arst_n),
        .din    ({board_temp_alert_in, chained_sysmgmt_in, chassis_i, sysmgmt_irq_i}),
        .dout   ({alert_n_s, chained_n_s, chassis_s, smi_pin_s})
    );
    hmic_sync #(.W(NAND_W), .INIT('1)) u_sync_nand (
        .mclk   (mclk),
        .arst_n (arst_n),
        .din    (nand_pins),
        .dout   (nand_s)
    );

    hmic_loop_t              loop_q, loop_d;
    logic [CW-1:0]           sel_q, sel_d;
    logic [$clog2(STEP_CYCLES+1)-1:0] step_q, step_d;
    logic                    step_end, loop_end;
    logic                    temp_armed_q, temp_armed_d;
    logic [7:0]              st1_q, st1_d, st2_q, st2_d, set1, set2, rdata_q, rdata_d;
    logic                    ram_ovf_evt;
    hmic_temp_t              temp_rd;

    // Monitoring loop sequencer; hold freezes it where it stands
    always_comb begin
        loop_d = loop_q;
        sel_d  = sel_q;
        step_d = step_q;
        step_end = 1'b0;
        unique case (loop_q)
            HMIC_LOOP_IDLE: if (cfg_start && !cfg_irq_line_hold) loop_d = HMIC_LOOP_RUN;
            HMIC_LOOP_RUN: begin
                if (cfg_irq_line_hold) begin
                    loop_d = HMIC_LOOP_HOLD; // [RQ16]
                end else if (!cfg_start) begin
                    loop_d = HMIC_LOOP_IDLE;
                end else if (step_q == STEP_CYCLES[$bits(step_q)-1:0] - 1'b1) begin
                    step_d   = '0;
                    step_end = 1'b1; // [RQ24]
                    sel_d    = (sel_q == CW'(NCH - 1)) ? '0 : sel_q + 1'b1;
                end else begin
                    step_d = step_q + 1'b1;
                end
            end
            HMIC_LOOP_HOLD: if (!cfg_irq_line_hold) loop_d = HMIC_LOOP_RUN; // [RQ16]
        endcase
        loop_end = step_end && (sel_q == CW'(NCH - 1));
    end

    // Temperature reading is channel 0, compared signed
    always_comb begin
        temp_rd      = hmic_temp_t'(chan_value); // [RQ1]
        temp_armed_d = temp_armed_q;
        set1         = 8'h00;
        set2         = 8'h00;
        if (step_end) begin
            if (sel_q == '0) begin
                if (hysteresis_setpoint == hmic_temp_t'(`HMIC_TEMP_COMPARATOR)) begin
                    // Thermostat: resets each read, reasserts each loop while hot
                    set1[`HMIC_ST1_TEMP] = temp_rd > overtemp_setpoint; // [RQ4] [RQ5] [RQ6]
                    temp_armed_d = 1'b1;
                end else if (temp_armed_q && temp_rd > overtemp_setpoint) begin
                    set1[`HMIC_ST1_TEMP] = 1'b1; // [RQ2]
                    temp_armed_d = 1'b0;
                end else if (!temp_armed_q && temp_rd < hysteresis_setpoint) begin
                    set1[`HMIC_ST1_TEMP] = 1'b1; // [RQ3]
                    temp_armed_d = 1'b1;
                end
            end else begin
                set1[sel_q] = (chan_value > chan_hi_limit) || (chan_value < chan_lo_limit); // [RQ7]
            end
        end
        // Level sources are sampled at loop end so a read stays clear until then
        if (loop_end) begin
            set2[`HMIC_ST2_BOARD_ALERT] = !alert_n_s; // [RQ8]
            set2[`HMIC_ST2_CHASSIS]     = chassis_s && !chassis_oe; // [RQ9]
            set2[`HMIC_ST2_CHAINED]     = !chained_n_s; // [RQ10]
        end
        set2[`HMIC_ST2_RAM_OVF] = ram_ovf_evt; // [RQ7] [RQ20]
    end

    // Status registers: read returns then clears; a set in the same cycle wins
    always_comb begin
        st1_d   = (st1_q & ~(stat1_rd ? 8'hff : 8'h00)) | set1; // [RQ11] [RQ13]
        st2_d   = (st2_q & ~(stat2_rd ? 8'hff : 8'h00)) | set2; // [RQ11] [RQ13]
        rdata_d = stat1_rd ? st1_q : (stat2_rd ? st2_q : rdata_q);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            loop_q       <= HMIC_LOOP_IDLE;
            sel_q        <= '0;
            step_q       <= '0;
            temp_armed_q <= 1'b1;
            st1_q        <= `HMIC_STATUS_RESET;
            st2_q        <= `HMIC_STATUS_RESET;
            rdata_q      <= 8'h00;
        end else begin
            loop_q       <= loop_d;
            sel_q        <= sel_d;
            step_q       <= step_d;
            temp_armed_q <= temp_armed_d;
            st1_q        <= st1_d;
            st2_q        <= st2_d;
            rdata_q      <= rdata_d;
        end
    end

    // Interrupt outputs: mask bit high blocks a source, hold forces release
    logic host_act, smi_act, host_act_q, host_n_q, host_n_d, smi_oe_q, smi_oe_d;
    logic test_q, test_d;
    logic nand_tree, nout_q, nout_d;
    always_comb begin
        host_act = |(st1_q & ~host_mask1) || |(st2_q & ~host_mask2); // [RQ11] [RQ14]
        smi_act  = |(st1_q & ~sysmgmt_mask1) || |(st2_q & ~sysmgmt_mask2) || !chained_n_s; // [RQ10]
        host_act = host_act && cfg_host_irq_en && !cfg_irq_line_hold; // [RQ12] [RQ16]
        smi_act  = smi_act && cfg_sysmgmt_irq_en && !cfg_irq_line_hold; // [RQ12] [RQ16]
        // Pulse mode gives one low cycle per new assertion
        host_n_d = cfg_host_irq_pulse ? !(host_act && !host_act_q) : !host_act; // [RQ12]
        smi_oe_d = smi_act && !test_q;
        // Tester pull seen with start low and hold high, in any loop state
        test_d   = test_q ? !cfg_start
                 : (!cfg_start && cfg_irq_line_hold && !smi_oe_q && !smi_pin_s); // [RQ22]
    end

    // Wide nand of all test pins: from all-high, any single pin toggles the output
    always_comb begin
        nand_tree = 1'b1;
        for (int i = 0; i < NAND_W; i++) begin
            nand_tree = nand_tree && nand_s[i]; // [RQ23]
        end
        nout_d = test_q ? !nand_tree : 1'b0;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            host_act_q <= 1'b0;
            host_n_q   <= 1'b1;
            smi_oe_q   <= 1'b0;
            test_q     <= 1'b0;
            nout_q     <= 1'b0;
        end else begin
            host_act_q <= host_act;
            host_n_q   <= host_n_d;
            smi_oe_q   <= smi_oe_d;
            test_q     <= test_d;
            nout_q     <= nout_d;
        end
    end

    // Two 20 ms low pulses; the starting bit reads back set until the pulse ends
    logic [$clog2(PULSE_CYC+1)-1:0] rst_cnt_q, rst_cnt_d, chs_cnt_q, chs_cnt_d;
    always_comb begin
        rst_cnt_d = rst_cnt_q;
        chs_cnt_d = chs_cnt_q;
        if (rst_cnt_q != '0) rst_cnt_d = rst_cnt_q - 1'b1;
        else if (cfg_reset_pulse_wr && sysmgmt_mask2[7]) rst_cnt_d = ($bits(rst_cnt_q))'(PULSE_CYC); // [RQ18]
        if (chs_cnt_q != '0) chs_cnt_d = chs_cnt_q - 1'b1;
        else if (chassis_clr_wr) chs_cnt_d = ($bits(chs_cnt_q))'(PULSE_CYC); // [RQ9]
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_cnt_q <= '0;
            chs_cnt_q <= '0;
        end else begin
            rst_cnt_q <= rst_cnt_d;
            chs_cnt_q <= chs_cnt_d;
        end
    end

    // Self-test code RAM with separate write and read pointers
    logic [7:0] ram_q [`HMIC_RAM_DEPTH];
    logic [5:0] wptr_q, wptr_d;
    logic [4:0] rptr_q, rptr_d;
    logic [7:0] prd_q, prd_d;
    logic       bypass_q;
    always_comb begin
        ram_ovf_evt = post_wr && (wptr_q == 6'(`HMIC_RAM_DEPTH)); // [RQ20]
        wptr_d = (post_wr && !ram_ovf_evt) ? wptr_q + 1'b1 : wptr_q; // [RQ19]
        rptr_d = rptr_q;
        prd_d  = prd_q;
        if (post_rd_load) begin
            rptr_d = post_rd_addr;
        end else if (post_rd) begin
            prd_d  = ram_q[rptr_q]; // [RQ21]
            rptr_d = (rptr_q == `HMIC_RAM_LAST) ? rptr_q : rptr_q + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wptr_q   <= '0;
            rptr_q   <= '0;
            prd_q    <= 8'h00;
            bypass_q <= 1'b0;
        end else begin
            wptr_q   <= wptr_d;
            rptr_q   <= rptr_d;
            prd_q    <= prd_d;
            bypass_q <= cfg_pwr_bypass; // [RQ17]
        end
    end

    // Storage has no reset; only written slots are meaningful
    always_ff @(posedge mclk) begin
        if (post_wr && !ram_ovf_evt) ram_q[wptr_q[4:0]] <= post_wdata; // [RQ19]
    end

    assign chan_sel              = sel_q;
    assign stat_rdata            = rdata_q;
    assign loop_done             = loop_end;
    assign host_irq_out          = host_n_q;
    assign sysmgmt_irq_o         = 1'b0;
    assign sysmgmt_irq_oe        = smi_oe_q;
    assign reset_o               = 1'b0;
    assign reset_oe              = rst_cnt_q != '0;
    assign cfg_reset_busy        = rst_cnt_q != '0;
    assign chassis_o             = 1'b0;
    assign chassis_oe            = chs_cnt_q != '0;
    assign chassis_clr_busy      = chs_cnt_q != '0;
    assign pwr_bypass_n          = !bypass_q;
    assign post_rdata            = prd_q;
    assign conn_test_mode        = test_q;
    assign connectivity_test_out = nout_q;

    // Refused at elaboration: select width and pulse counter cannot serve these
    if (NCH < 2 || NCH > 8) begin : g_bad_nch
        $error("hmic_top: NCH must be 2..8");
    end
    if (STEP_CYCLES < 2 || PULSE_CYC < 8) begin : g_bad_cnt
        $error("hmic_top: counts too small");
    end

    sequence s_hot_step;
        step_end && sel_q == '0 && hysteresis_setpoint == hmic_temp_t'(`HMIC_TEMP_COMPARATOR)
            && temp_rd > overtemp_setpoint;
    endsequence
    sequence s_clear_read;
        stat1_rd && !step_end;
    endsequence

    a_thermo_set: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ5]
        s_hot_step |=> st1_q[`HMIC_ST1_TEMP]) else $error("thermostat bit not set");
    a_read_clear: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ13]
        s_clear_read |=> !st1_q[`HMIC_ST1_TEMP] && stat_rdata == $past(st1_q))
        else $error("status read did not clear");
    a_hold_release: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ16]
        cfg_irq_line_hold |=> (host_irq_out && !sysmgmt_irq_oe)) else $error("hold left a line active");
    a_hold_freeze: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ16]
        loop_q == HMIC_LOOP_HOLD |-> !step_end) else $error("loop ran during hold");
    a_bypass_follow: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ17]
        cfg_pwr_bypass [*2] |-> !pwr_bypass_n) else $error("bypass not driven low");
    a_reset_start: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ18]
        cfg_reset_pulse_wr && sysmgmt_mask2[7] && !reset_oe |=> reset_oe [*8]) else $error("reset pulse short");
    a_reset_gated: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ18]
        !reset_oe && !(cfg_reset_pulse_wr && sysmgmt_mask2[7]) |=> !reset_oe) else $error("reset pulse ungated");
    a_ram_stop: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ20]
        post_wr && wptr_q == 6'(`HMIC_RAM_DEPTH) |=> wptr_q == $past(wptr_q) && st2_q[`HMIC_ST2_RAM_OVF])
        else $error("overflow write mishandled");
    a_chassis_pulse: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ9]
        chassis_clr_wr && !chassis_oe |=> chassis_oe && chassis_clr_busy) else $error("chassis clear missing");
    a_rd_ptr_sat: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ21]
        post_rd && !post_rd_load && rptr_q == `HMIC_RAM_LAST |=> rptr_q == `HMIC_RAM_LAST)
        else $error("read pointer passed end");
endmodule
`default_nettype wire

//--- src/hmic_top_dummy_guard.sv
`default_nettype none
`default_nettype wire

//--- bench/hmic_far_model.sv
// Purpose: Far side of the block: channel readings, alert sources, chassis latch
// Assumes: Driven by the bench; pins resolved here
// Notes:   Channel 0 carries the temperature, others sit inside wide limits
`default_nettype none
module hmic_far_model
    import hmic_pkg::*;
(
    input  wire logic [2:0] chan_sel,
    input  wire hmic_temp_t temp,
    output logic      [7:0] chan_value,
    output logic      [7:0] chan_hi_limit,
    output logic      [7:0] chan_lo_limit,
    input  wire logic       alert,
    input  wire logic       chain,
    input  wire logic       intrude,
    input  wire logic       chassis_oe,
    input  wire logic       sysmgmt_irq_oe,
    output logic            board_temp_alert_in,
    output logic            chained_sysmgmt_in,
    output logic            chassis_i,
    output logic            sysmgmt_irq_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic latch_q = 1'h0;
    // Readings follow the selected channel at once
    assign chan_value    = (chan_sel == 3'h0) ? temp : 8'h40;
    assign chan_hi_limit = 8'hff;
    assign chan_lo_limit = 8'h00;
    // Alert sensors share a pulled-up line and pull it low
    assign board_temp_alert_in = ~alert;
    assign chained_sysmgmt_in  = ~chain;
    // Intrusion circuit latches the event; only the block pulling low resets it
    always @(intrude, chassis_oe) begin
        if (chassis_oe)
            latch_q = 1'h0;
        else if (intrude)
            latch_q = 1'h1;
    end
    assign chassis_i     = latch_q & ~chassis_oe;
    assign sysmgmt_irq_i = ~(sysmgmt_irq_oe | chain); // Pulled-up line; tester pull rides on chain
endmodule
`default_nettype wire

//--- bench/hmic_top_tb.sv
// Purpose: Self-checking bench of the monitor interrupt block
// Assumes: Short loop step and pulse length set by parameters
// Notes:   Status reads are checked against values worked out here
`default_nettype none
module hmic_top_tb import hmic_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC = 20;
    logic mclk = 1'h0, arst_n = 1'h0, cfg_start = 1'h0, cfg_irq_line_hold = 1'h0, cfg_host_irq_en = 1'h1;
    logic cfg_sysmgmt_irq_en = 1'h1, cfg_host_irq_pulse = 1'h0, cfg_pwr_bypass = 1'h0, cfg_reset_pulse_wr = 1'h0;
    logic chassis_clr_wr = 1'h0, stat1_rd = 1'h0, stat2_rd = 1'h0, post_wr = 1'h0, post_rd_load = 1'h0;
    logic post_rd = 1'h0, alert = 1'h0, chain = 1'h0, intrude = 1'h0;
    logic [7:0] host_mask1 = 8'h00, host_mask2 = 8'h00, sysmgmt_mask1 = 8'h00, sysmgmt_mask2 = 8'h00;
    logic [7:0] post_wdata = 8'h00, nand_pins = 8'hff, chan_value, chan_hi_limit, chan_lo_limit, stat_rdata, post_rdata;
    logic [4:0] post_rd_addr = 5'h00;
    hmic_temp_t temp = 8'sh19, overtemp_setpoint = 8'sh32, hysteresis_setpoint = 8'sh28;
    logic [2:0] chan_sel, sel_seen;
    logic loop_done, board_temp_alert_in, chained_sysmgmt_in, chassis_i, chassis_o, chassis_oe, chassis_clr_busy;
    logic host_irq_out, sysmgmt_irq_i, sysmgmt_irq_o, sysmgmt_irq_oe, reset_o, reset_oe, cfg_reset_busy;
    logic pwr_bypass_n, conn_test_mode, connectivity_test_out;
    int err_total = 0, cmp_count = 0;
    // 50 MHz clock
    always #10 mclk = ~mclk;
    hmic_top #(.NCH(8), .STEP_CYCLES(4), .PULSE_CYC(PC), .NAND_W(8)) i_hmic_top (
        .mclk, .arst_n, .cfg_start, .cfg_irq_line_hold, .cfg_host_irq_en, .cfg_sysmgmt_irq_en,
        .cfg_host_irq_pulse, .cfg_pwr_bypass, .cfg_reset_pulse_wr, .chassis_clr_wr, .host_mask1,
        .host_mask2, .sysmgmt_mask1, .sysmgmt_mask2, .chan_sel, .chan_value, .chan_hi_limit,
        .chan_lo_limit, .overtemp_setpoint, .hysteresis_setpoint, .stat1_rd, .stat2_rd, .stat_rdata,
        .loop_done, .board_temp_alert_in, .chained_sysmgmt_in, .chassis_i, .chassis_o, .chassis_oe,
        .chassis_clr_busy, .host_irq_out, .sysmgmt_irq_i, .sysmgmt_irq_o, .sysmgmt_irq_oe, .reset_o,
        .reset_oe, .cfg_reset_busy, .pwr_bypass_n, .post_wr, .post_wdata, .post_rd_load, .post_rd_addr,
        .post_rd, .post_rdata, .nand_pins, .conn_test_mode, .connectivity_test_out);
    hmic_far_model i_hmic_far_model (.chan_sel, .temp, .chan_value, .chan_hi_limit, .chan_lo_limit,
        .alert, .chain, .intrude, .chassis_oe, .sysmgmt_irq_oe, .board_temp_alert_in,
        .chained_sysmgmt_in, .chassis_i, .sysmgmt_irq_i);
    // Verdict and end of run
    task automatic wrap_up();
        $display("counts: %0d compared, %0d wrong", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // Inputs move 2 ns after the edge, never on it
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    // Wait for whole monitoring loops; a stuck loop ends the run
    task automatic loops(input int n);
        int k;
        int c;
        k = 0;
        c = 0;
        while (k < n && c < 200 * n) begin
            @(negedge mclk);
            c++;
            if (loop_done === 1'h1)
                k++;
        end
        cyc(1);
        if (k < n) begin
            err_total++;
            wrap_up();
        end
    endtask
    // Status read: answer stands from the cycle after the strobe
    task automatic rds(input logic s, input logic [7:0] e, input string n);
        stat1_rd = ~s;
        stat2_rd = s;
        cyc(1);
        stat1_rd = 1'h0;
        stat2_rd = 1'h0;
        cyc(1);
        chk(n, e, stat_rdata);
    endtask
    // Self-clearing pulse request; counts cycles the line is pulled low
    task automatic pls(input logic ch, input logic [7:0] e);
        int n;
        n = 0;
        chassis_clr_wr = ch;
        cfg_reset_pulse_wr = ~ch;
        cyc(1);
        chassis_clr_wr = 1'h0;
        cfg_reset_pulse_wr = 1'h0;
        repeat (60) begin
            @(negedge mclk);
            if ((ch ? chassis_oe : reset_oe) === 1'h1)
                n++;
        end
        cyc(1);
        chk("pulse", e, n[7:0]);
    endtask
    task automatic prd(input logic [7:0] e);
        post_rd = 1'h1;
        cyc(1);
        post_rd = 1'h0;
        cyc(1);
        chk("post", e, post_rdata);
    endtask
    // Main sequence
    initial begin
        cyc(5);
        arst_n = 1'h1;
        chk("irq", 8'h01, host_irq_out);
        chk("byp", 8'h01, pwr_bypass_n);
        cfg_start = 1'h1;
        loops(2);
        rds(1'h0, 8'h00, "st1");
        temp = 8'sh7d;
        loops(2);
        chk("irq", 8'h00, host_irq_out);
        rds(1'h0, 8'h01, "st1");
        rds(1'h0, 8'h00, "st1");
        chk("irq", 8'h01, host_irq_out);
        loops(2);
        rds(1'h0, 8'h00, "st1");
        temp = 8'shc9;
        loops(2);
        rds(1'h0, 8'h01, "st1");
        $display("test default mode done");
        hysteresis_setpoint = 8'sh7f;
        temp = 8'sh7d;
        loops(2);
        rds(1'h0, 8'h01, "st1");
        loops(2);
        rds(1'h0, 8'h01, "st1");
        host_mask1 = 8'h01;
        loops(2);
        chk("irq", 8'h01, host_irq_out);
        host_mask1 = 8'h00;
        cyc(3);
        chk("irq", 8'h00, host_irq_out);
        cfg_host_irq_pulse = 1'h1;
        cyc(2);
        chk("irq", 8'h01, host_irq_out);
        cfg_host_irq_pulse = 1'h0;
        cfg_host_irq_en = 1'h0;
        cyc(2);
        chk("irq", 8'h01, host_irq_out);
        cfg_host_irq_en = 1'h1;
        cfg_irq_line_hold = 1'h1;
        cyc(3);
        sel_seen = chan_sel;
        chk("irq", 8'h01, host_irq_out);
        cyc(40);
        chk("sel", {5'h00, sel_seen}, {5'h00, chan_sel});
        cfg_irq_line_hold = 1'h0;
        temp = 8'sh19;
        loops(3);
        rds(1'h0, 8'h01, "st1");
        loops(2);
        rds(1'h0, 8'h00, "st1");
        $display("test thermostat done");
        alert = 1'h1;
        chain = 1'h1;
        cyc(8);
        chk("smi", 8'h01, sysmgmt_irq_oe);
        loops(2);
        alert = 1'h0;
        chain = 1'h0;
        cyc(6);
        loops(1);
        rds(1'h1, 8'h05, "st2");
        intrude = 1'h1;
        cyc(6);
        intrude = 1'h0;
        loops(1);
        pls(1'h1, PC);
        rds(1'h1, 8'h02, "st2");
        loops(1);
        rds(1'h1, 8'h00, "st2");
        pls(1'h0, 8'h00);
        sysmgmt_mask2 = 8'h80;
        pls(1'h0, PC);
        chk("busy", 8'h00, cfg_reset_busy);
        cfg_pwr_bypass = 1'h1;
        cyc(3);
        chk("byp", 8'h00, pwr_bypass_n);
        $display("test external sources done");
        for (int i = 0; i < 33; i++) begin
            post_wr = 1'h1;
            post_wdata = 8'(i + 16);
            cyc(1);
        end
        post_wr = 1'h0;
        cyc(2);
        rds(1'h1, 8'h08, "st2");
        post_rd_load = 1'h1;
        post_rd_addr = 5'h1e;
        cyc(1);
        post_rd_load = 1'h0;
        prd(8'h2e);
        prd(8'h2f);
        prd(8'h2f);
        cfg_start = 1'h0;
        cfg_irq_line_hold = 1'h1;
        chain = 1'h1;
        cyc(8);
        chk("tst", 8'h01, conn_test_mode);
        nand_pins = 8'hfe;
        cyc(6);
        chk("nand", 8'h01, connectivity_test_out);
        $display("test code ram done");
        wrap_up();
    end
endmodule
`default_nettype wire
